// file: include/evrt_pkg.sv
// Constants, state layout and helpers for the event router.
// Assumes a single 20 MHz system clock and an AHB-Lite register bus.
package evrt_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_ASYNC_CH   = 4;
  localparam int NUM_SYNC_CH    = 2;
  localparam int NUM_CH         = 6;
  localparam int NUM_ASYNC_USER = 13;
  localparam int NUM_SYNC_USER  = 2;
  localparam int NUM_PINS       = 3;
  localparam int PIN_USER_BASE  = 8;
  localparam int GEN_W          = 32;
  localparam int SEL_W          = 8;
  localparam int IDX_W          = 6;

  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_ASYNC_STROBE    = 6'h00;
  localparam logic [IDX_W-1:0] IDX_SYNC_STROBE     = 6'h01;
  localparam logic [IDX_W-1:0] IDX_ASYNC_CH_BASE   = 6'h02;
  localparam logic [IDX_W-1:0] IDX_SYNC_CH_BASE    = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_ASYNC_USER_BASE = 6'h12;
  localparam logic [IDX_W-1:0] IDX_SYNC_USER_BASE  = 6'h22;
  localparam logic [IDX_W-1:0] IDX_PIN_ENABLE      = 6'h24;
  localparam logic [IDX_W-1:0] IDX_CHAN_LEVEL      = 6'h25;

  // ----------------------------------------
  // Selector codes
  // ----------------------------------------
  typedef logic [SEL_W-1:0] evrt_sel_type;
  localparam evrt_sel_type SEL_OFF     = 8'h00;
  localparam evrt_sel_type USEL_ASYNC0 = 8'h03;
  localparam evrt_sel_type USEL_LAST   = 8'h06;
  localparam evrt_sel_type SUSEL_LAST  = 8'h02;
  localparam evrt_sel_type GSEL_LAST   = 8'h20;

  // ----------------------------------------
  // Bus codes
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // ----------------------------------------
  // State of the top module
  // ----------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0]                       a_strobe;
    logic [SEL_W-1:0]                       s_strobe;
    logic [NUM_ASYNC_CH-1:0]                a_pulse;
    logic [NUM_SYNC_CH-1:0]                 s_pulse;
    logic [NUM_ASYNC_CH-1:0][SEL_W-1:0]     a_src;
    logic [NUM_SYNC_CH-1:0][SEL_W-1:0]      s_src;
    logic [NUM_ASYNC_USER-1:0][SEL_W-1:0]   a_user;
    logic [NUM_SYNC_USER-1:0][SEL_W-1:0]    s_user;
    logic [NUM_PINS-1:0]                    pin_en;
    logic [NUM_CH-1:0]                      lvl_meta;
    logic [NUM_CH-1:0]                      lvl_sync;
    logic                                   wr_pend;
    logic                                   map_ok;
    logic [IDX_W-1:0]                       wr_idx;
    logic [31:0]                            rdata;
    logic                                   ready;
    logic                                   resp;
  } evrt_state_type;

  localparam evrt_state_type EVRT_STATE_RST = '{ready: 1'b1, default: '0};

  // Generator pick: zero leaves the channel disconnected
  function automatic logic evrt_gen_pick(input evrt_sel_type sel,
                                         input logic [GEN_W-1:0] gen);
    evrt_sel_type idx;
    idx = sel - 8'h01;
    if (sel == SEL_OFF || sel > GSEL_LAST) begin
      return 1'b0;
    end
    return gen[idx[4:0]];
  endfunction : evrt_gen_pick

endpackage : evrt_pkg

// file: include/evrt_route_if.sv
// Carries channel levels and user selectors from the router to the user muxes.
// Assumes both ends import evrt_pkg.
`timescale 1ns/1ps
`default_nettype none
interface evrt_route_if;
  import evrt_pkg::*;
  logic [NUM_CH-1:0]                     chan;
  logic [NUM_ASYNC_USER-1:0][SEL_W-1:0]  a_user_sel;
  logic [NUM_SYNC_USER-1:0][SEL_W-1:0]   s_user_sel;
  logic [NUM_ASYNC_USER-1:0]             a_user_ev;
  logic [NUM_SYNC_USER-1:0]              s_user_ev;

  modport router (output chan, a_user_sel, s_user_sel, input a_user_ev, s_user_ev);
  modport mux    (input chan, a_user_sel, s_user_sel, output a_user_ev, s_user_ev);
endinterface : evrt_route_if
`default_nettype wire

// file: design/evrt_user_mux.sv
// Per-user channel multiplexers, purely combinational.
// Assumes selectors come from registers on the system clock.
`timescale 1ns/1ps
`default_nettype none
module evrt_user_mux (
  // Clock and reset, for checks only
  input  wire logic   i_sys_clk,
  input  wire logic   i_rst_b,
  // Routing bundle
  evrt_route_if.mux   rif
);
  import evrt_pkg::*;

  // ----------------------------------------
  // Selection decode
  // ----------------------------------------
  // Codes 1..2 pick sync channels, 3..6 async ones; anything else is off
  function automatic logic evrt_pick_chan(input evrt_sel_type sel,
                                          input logic [NUM_CH-1:0] chan,
                                          input evrt_sel_type last);
    evrt_sel_type idx;
    idx = sel - 8'h01;
    if (sel == SEL_OFF || sel > last) begin
      return 1'b0;
    end
    return chan[idx[2:0]];
  endfunction : evrt_pick_chan

  // One dedicated mux per user; no clock on this path
  for (genvar u = 0; u < NUM_ASYNC_USER; u++) begin : g_auser
    assign rif.a_user_ev[u] = evrt_pick_chan(rif.a_user_sel[u], rif.chan, USEL_LAST);
  end
  // Sync-only users never see async channels
  for (genvar u = 0; u < NUM_SYNC_USER; u++) begin : g_suser
    assign rif.s_user_ev[u] = evrt_pick_chan(rif.s_user_sel[u], rif.chan, SUSEL_LAST);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  for (genvar u = 0; u < NUM_ASYNC_USER; u++) begin : g_chk
    chk_user_off_sel: assert property (
      rif.a_user_sel[u] == SEL_OFF |-> !rif.a_user_ev[u])
      else $error("user mux off but event passes");
    chk_user_async_zero: assert property (
      rif.a_user_sel[u] == USEL_ASYNC0 |-> rif.a_user_ev[u] == rif.chan[NUM_SYNC_CH])
      else $error("async channel zero not routed to user");
  end

  chk_sync_user_range: assert property (
    rif.s_user_sel[0] > SUSEL_LAST |-> !rif.s_user_ev[0])
    else $error("sync-only user reached an async channel");

endmodule : evrt_user_mux
`default_nettype wire

// file: design/evrt_top.sv
// Event router: channel sources, software strobes, user muxes, event pins.
// Assumes AHB-Lite single word transfers and one 20 MHz system clock.
//
// Notes on behaviour
// - Strobe inverts channel for one clock cycle
// - Strobe bit one injects event on channel
// - Users see strobe like a hardware event
// - One generator per channel, shareable across channels
// - Many users may share one channel
// - Four async channels, two sync channels
// - Each user owns one dedicated mux
// - Sync-only users select sync channels only
// - User muxes select nothing after reset
// - Channels connect no generator after reset
// - Channels pass pulses or levels unchanged
// - Three pins driven from users eight-ten
// - Pin drives only when its enable set
// - Registers clocked; routing path needs no clock
// - Strobes need clock; routing works asleep
// - Async events synchronised inside users; router syncs levels for readback only
// - Debug state leaves router unchanged
// - User code 0 off, 1-2 sync, 3-6 async
// - Sync user code 0 off, 1-2 sync
// - Source code zero disconnects the channel
`timescale 1ns/1ps
`default_nettype none
module evrt_top (
  // Clock and reset
  input  wire logic                                   I_SYS_CLK,
  input  wire logic                                   I_RST_B,
  // AHB-Lite slave
  input  wire logic                                   I_HSEL,
  input  wire logic [31:0]                            I_HADDR,
  input  wire logic [1:0]                             I_HTRANS,
  input  wire logic                                   I_HWRITE,
  input  wire logic [2:0]                             I_HSIZE,
  input  wire logic [31:0]                            I_HWDATA,
  input  wire logic                                   I_HREADY,
  output logic                                        O_HREADYOUT,
  output logic                                        O_HRESP,
  output logic [31:0]                                 O_HRDATA,
  // Event generators
  input  wire logic [evrt_pkg::GEN_W-1:0]             I_ASYNC_GEN,
  input  wire logic [evrt_pkg::GEN_W-1:0]             I_SYNC_GEN,
  // Event users
  output logic [evrt_pkg::NUM_ASYNC_USER-1:0]         O_ASYNC_USER_EV,
  output logic [evrt_pkg::NUM_SYNC_USER-1:0]          O_SYNC_USER_EV,
  // Event pins
  output logic [evrt_pkg::NUM_PINS-1:0]               O_EVENT_PIN_OUT,
  output logic [evrt_pkg::NUM_PINS-1:0]               O_EVENT_PIN_OE
);
  import evrt_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  evrt_state_type   st;
  evrt_state_type   next_st;
  logic             take;
  logic             a_ok;
  logic [IDX_W-1:0] a_idx;
  logic             wr_now;
  logic [31:0]      rv;

  evrt_route_if rif ();

  // Address phase decode; size is not checked, only whole words are used
  assign take   = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
  assign a_idx  = I_HADDR[IDX_W+1:2];
  assign a_ok   = (I_HADDR[31:IDX_W+2] == '0) && (I_HADDR[1:0] == 2'h0);
  assign wr_now = st.wr_pend && st.map_ok;

  // ----------------------------------------
  // Channel network
  // ----------------------------------------
  // Combinational so routing keeps working with the clock stopped; async
  // sources are left unsynchronised here, the users resynchronise them
  always_comb begin
    for (int k = 0; k < NUM_SYNC_CH; k++) begin
      rif.chan[k] = evrt_gen_pick(st.s_src[k], I_SYNC_GEN) ^ st.s_pulse[k];
    end
    for (int k = 0; k < NUM_ASYNC_CH; k++) begin
      rif.chan[NUM_SYNC_CH+k] = evrt_gen_pick(st.a_src[k], I_ASYNC_GEN) ^ st.a_pulse[k];
    end
  end

  assign rif.a_user_sel = st.a_user;
  assign rif.s_user_sel = st.s_user;

  evrt_user_mux u_mux (
    .i_sys_clk (I_SYS_CLK),
    .i_rst_b   (I_RST_B),
    .rif       (rif.mux)
  );

  // ----------------------------------------
  // Register file and bus slave
  // ----------------------------------------
  always_comb begin
    rv                = '0;
    next_st           = st;
    // Strobe pulses last one cycle only
    next_st.a_pulse   = '0;
    next_st.s_pulse   = '0;
    // Level readback through two flops, since async levels are unclocked
    next_st.lvl_meta  = rif.chan;
    next_st.lvl_sync  = st.lvl_meta;
    next_st.ready     = 1'b1;
    next_st.resp      = HRESP_OKAY;
    // Data phase write; needs the clock, so strobes are dead in deep sleep
    if (wr_now) begin
      if (st.wr_idx == IDX_ASYNC_STROBE) begin
        next_st.a_strobe = I_HWDATA[SEL_W-1:0];
        next_st.a_pulse  = I_HWDATA[NUM_ASYNC_CH-1:0];
      end
      if (st.wr_idx == IDX_SYNC_STROBE) begin
        next_st.s_strobe = I_HWDATA[SEL_W-1:0];
        next_st.s_pulse  = I_HWDATA[NUM_SYNC_CH-1:0];
      end
      for (int k = 0; k < NUM_ASYNC_CH; k++) begin
        if (st.wr_idx == IDX_W'(IDX_ASYNC_CH_BASE + k)) begin
          next_st.a_src[k] = I_HWDATA[SEL_W-1:0];
        end
      end
      for (int k = 0; k < NUM_SYNC_CH; k++) begin
        if (st.wr_idx == IDX_W'(IDX_SYNC_CH_BASE + k)) begin
          next_st.s_src[k] = I_HWDATA[SEL_W-1:0];
        end
      end
      for (int u = 0; u < NUM_ASYNC_USER; u++) begin
        if (st.wr_idx == IDX_W'(IDX_ASYNC_USER_BASE + u)) begin
          next_st.a_user[u] = I_HWDATA[SEL_W-1:0];
        end
      end
      for (int u = 0; u < NUM_SYNC_USER; u++) begin
        if (st.wr_idx == IDX_W'(IDX_SYNC_USER_BASE + u)) begin
          next_st.s_user[u] = I_HWDATA[SEL_W-1:0];
        end
      end
      if (st.wr_idx == IDX_PIN_ENABLE) begin
        next_st.pin_en = I_HWDATA[NUM_PINS-1:0];
      end
    end
    // Read mux; unmapped words read as zero
    if (a_ok) begin
      if (a_idx == IDX_ASYNC_STROBE) begin
        rv[SEL_W-1:0] = st.a_strobe;
      end
      if (a_idx == IDX_SYNC_STROBE) begin
        rv[SEL_W-1:0] = st.s_strobe;
      end
      for (int k = 0; k < NUM_ASYNC_CH; k++) begin
        if (a_idx == IDX_W'(IDX_ASYNC_CH_BASE + k)) begin
          rv[SEL_W-1:0] = st.a_src[k];
        end
      end
      for (int k = 0; k < NUM_SYNC_CH; k++) begin
        if (a_idx == IDX_W'(IDX_SYNC_CH_BASE + k)) begin
          rv[SEL_W-1:0] = st.s_src[k];
        end
      end
      for (int u = 0; u < NUM_ASYNC_USER; u++) begin
        if (a_idx == IDX_W'(IDX_ASYNC_USER_BASE + u)) begin
          rv[SEL_W-1:0] = st.a_user[u];
        end
      end
      for (int u = 0; u < NUM_SYNC_USER; u++) begin
        if (a_idx == IDX_W'(IDX_SYNC_USER_BASE + u)) begin
          rv[SEL_W-1:0] = st.s_user[u];
        end
      end
      if (a_idx == IDX_PIN_ENABLE) begin
        rv[NUM_PINS-1:0] = st.pin_en;
      end
      if (a_idx == IDX_CHAN_LEVEL) begin
        rv[NUM_CH-1:0] = st.lvl_sync;
      end
    end
    // Address phase capture; zero wait states
    next_st.wr_pend = take && I_HWRITE;
    next_st.wr_idx  = a_idx;
    next_st.map_ok  = a_ok;
    if (take && !I_HWRITE) begin
      next_st.rdata = rv;
    end
  end

  // State register; no debug input, so halting the core changes nothing
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      st <= EVRT_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_HREADYOUT     = st.ready;
  assign O_HRESP         = st.resp;
  assign O_HRDATA        = st.rdata;
  assign O_ASYNC_USER_EV = rif.a_user_ev;
  assign O_SYNC_USER_EV  = rif.s_user_ev;
  assign O_EVENT_PIN_OE  = st.pin_en;

  // Pins follow users eight to ten, gated by their enables
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign O_EVENT_PIN_OUT[p] = rif.a_user_ev[PIN_USER_BASE+p] & st.pin_en[p];
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_B);

  // A strobe is two steps: the channel inverted for one cycle, then restored
  // to whatever its generator shows, so a moving generator is no false alarm
  sequence s_inv_async(int k);
    rif.chan[NUM_SYNC_CH+k] == !evrt_gen_pick(st.a_src[k], I_ASYNC_GEN)
      ##1 rif.chan[NUM_SYNC_CH+k] == evrt_gen_pick(st.a_src[k], I_ASYNC_GEN);
  endsequence

  sequence s_inv_sync(int k);
    rif.chan[k] == !evrt_gen_pick(st.s_src[k], I_SYNC_GEN)
      ##1 rif.chan[k] == evrt_gen_pick(st.s_src[k], I_SYNC_GEN);
  endsequence

  for (genvar k = 0; k < NUM_ASYNC_CH; k++) begin : g_chk_a
    chk_async_strobe_inv: assert property (
      wr_now && st.wr_idx == IDX_ASYNC_STROBE && I_HWDATA[k] |=> s_inv_async(k))
      else $error("async strobe did not invert channel once");
    chk_async_strobe_zero: assert property (
      wr_now && st.wr_idx == IDX_ASYNC_STROBE && !I_HWDATA[k] |=> !st.a_pulse[k])
      else $error("zero strobe bit produced an event");
    chk_async_src_off: assert property (
      st.a_src[k] == SEL_OFF && !st.a_pulse[k] |-> !rif.chan[NUM_SYNC_CH+k])
      else $error("disconnected channel not idle");
  end

  for (genvar k = 0; k < NUM_SYNC_CH; k++) begin : g_chk_s
    chk_sync_strobe_inv: assert property (
      wr_now && st.wr_idx == IDX_SYNC_STROBE && I_HWDATA[k] |=> s_inv_sync(k))
      else $error("sync strobe did not invert channel once");
    chk_sync_strobe_zero: assert property (
      wr_now && st.wr_idx == IDX_SYNC_STROBE && !I_HWDATA[k] |=> !st.s_pulse[k])
      else $error("zero sync strobe bit produced an event");
    chk_sync_src_off: assert property (
      st.s_src[k] == SEL_OFF && !st.s_pulse[k] |-> !rif.chan[k])
      else $error("disconnected sync channel not idle");
  end

  // Reset is watched with the disable lifted, since reset is what is checked
  chk_reset_all_off: assert property (
    @(posedge I_SYS_CLK) disable iff (1'b0)
    !I_RST_B |=> (st.a_user == '0) && (st.s_user == '0) && (st.a_src == '0) && (st.s_src == '0))
    else $error("selectors not cleared by reset");

  chk_pin_gate_off: assert property (
    !st.pin_en[0] |-> !O_EVENT_PIN_OUT[0] && !O_EVENT_PIN_OE[0])
    else $error("pin driven while disabled");

  chk_pin_follows_user: assert property (
    st.pin_en[2] |-> O_EVENT_PIN_OE[2] && O_EVENT_PIN_OUT[2] == O_ASYNC_USER_EV[PIN_USER_BASE+2])
    else $error("enabled pin does not follow user ten");

  // Each pin is gated by its own enable and follows its own user
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_chk_pin
    chk_pin_each_gate: assert property (
      O_EVENT_PIN_OUT[p] == (O_ASYNC_USER_EV[PIN_USER_BASE+p] && O_EVENT_PIN_OE[p]))
      else $error("event pin not gated by its enable");
  end

  // A pulse clears at the next edge unless another strobe write lands there
  chk_pulse_one_cycle: assert property (
    st.a_pulse != '0 && !(wr_now && st.wr_idx == IDX_ASYNC_STROBE) |=> st.a_pulse == '0)
    else $error("async strobe pulse held beyond one cycle");

  chk_sync_pulse_one: assert property (
    st.s_pulse != '0 && !(wr_now && st.wr_idx == IDX_SYNC_STROBE) |=> st.s_pulse == '0)
    else $error("sync strobe pulse held beyond one cycle");

  // Selector writes land at the data-phase edge
  chk_user_sel_write: assert property (
    wr_now && st.wr_idx == IDX_ASYNC_USER_BASE |=> st.a_user[0] == $past(I_HWDATA[SEL_W-1:0]))
    else $error("user selector write did not land");

  chk_bus_zero_wait: assert property (
    O_HREADYOUT && O_HRESP == HRESP_OKAY)
    else $error("slave stalled or answered with error");

  // Read data is the register as it stood at the address-phase edge
  chk_read_src_back: assert property (
    take && !I_HWRITE && a_ok && a_idx == IDX_ASYNC_CH_BASE
      |=> O_HRDATA == {24'h000000, $past(st.a_src[0])})
    else $error("channel source readback wrong");

endmodule : evrt_top
`default_nettype wire

// file: tb/evrt_gen_model.sv
// Partner model: the on-chip event generators that feed the router.
// Assumes the bench seeds $urandom once and drives the freeze control.
`timescale 1ns/1ps
`default_nettype none
module evrt_gen_model (
  // Clock and control
  input  wire logic   i_clk,
  input  wire logic   i_hold,
  // Generator levels
  output logic [31:0] o_async_gen,
  output logic [31:0] o_sync_gen
);
  // ------------------------------------------------
  // Generators
  // ------------------------------------------------
  initial begin
    o_async_gen = 32'h0;
    o_sync_gen  = 32'h0;
  end
  // Clocked sources move right after the edge, so most bits act as short pulses
  always @(posedge i_clk) begin
    if (!i_hold) begin
      o_sync_gen <= $urandom;
    end
  end
  // Loose sources move 10 ns after the rising edge, away from any edge, and hold as levels
  always @(posedge i_clk) begin
    if (!i_hold && ($urandom % 2) == 0) begin
      o_async_gen <= #10 $urandom;
    end
  end
endmodule : evrt_gen_model
`default_nettype wire

// file: tb/tb_evrt_top.sv
// Self-checking bench for the event router top.
// Assumes zero-wait AHB-Lite slave and combinational routing to users and pins.
`timescale 1ns/1ps
`default_nettype none
module tb_evrt_top;
  import evrt_pkg::*;
  // ------------------------------------------------
  // Signals and shadow configuration
  // ------------------------------------------------
  logic                      clk, rst_b, hsel, hwrite, hold, hready, hresp;
  logic [1:0]                htrans;
  logic [31:0]               haddr, hwdata, hrdata, agen, sgen;
  logic [NUM_ASYNC_USER-1:0] a_ev;
  logic [NUM_SYNC_USER-1:0]  s_ev;
  logic [NUM_PINS-1:0]       pin, pin_oe, pen;
  logic [7:0]                src [NUM_CH];
  logic [7:0]                au  [NUM_ASYNC_USER];
  logic [7:0]                su  [NUM_SYNC_USER];
  int                        checks, num_errors;

  evrt_top DUT (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .I_ASYNC_GEN(agen), .I_SYNC_GEN(sgen), .O_ASYNC_USER_EV(a_ev), .O_SYNC_USER_EV(s_ev),
    .O_EVENT_PIN_OUT(pin), .O_EVENT_PIN_OE(pin_oe));
  evrt_gen_model gen (.i_clk(clk), .i_hold(hold), .o_async_gen(agen), .o_sync_gen(sgen));

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------
  // Expectations, worked out from the selector codings
  // ------------------------------------------------
  function automatic logic [5:0] exp_chan();
    logic [31:0] g;
    for (int c = 0; c < NUM_CH; c++) begin
      g = (c < NUM_SYNC_CH) ? sgen : agen;
      exp_chan[c] = (src[c] != 8'h00 && src[c] <= 8'h20) ? g[src[c] - 8'h01] : 1'b0;
    end
  endfunction : exp_chan
  // Reserved codes above the last one must select nothing
  function automatic logic pick(input logic [7:0] code, input logic [7:0] last, input logic [5:0] ch);
    return (code != 8'h00 && code <= last) ? ch[code - 8'h01] : 1'b0;
  endfunction : pick
  function automatic logic [5:0] src_idx(input int c);
    return (c < NUM_SYNC_CH) ? IDX_SYNC_CH_BASE + 6'(c) : IDX_ASYNC_CH_BASE + 6'(c - 2);
  endfunction : src_idx

  // ------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait for hready; a stuck bus ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) begin
      num_errors++;
      end_of_test();
    end
  endtask : wait_rdy
  // Write then read back, or read only; a strobe write is checked in its pulse cycle and after
  task automatic wrrd(input logic [5:0] idx, input logic [31:0] wd, input logic [31:0] exp,
                      input logic wr);
    logic       strb;
    logic [5:0] f;
    strb = wr && (idx == IDX_ASYNC_STROBE || idx == IDX_SYNC_STROBE);
    f    = (idx == IDX_SYNC_STROBE) ? {4'h0, wd[1:0]} : {wd[3:0], 2'b00};
    for (int k = wr ? 0 : 1; k < 2; k++) begin
      @(posedge clk);
      if (k == 1 && strb) begin
        #1;
        cmp_route(6'h0);
      end
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= (k == 0);
      haddr  <= {24'h0, idx, 2'b00};
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      check(32'(hresp), 32'(HRESP_OKAY));
      if (k == 0 && strb) begin
        #1;
        cmp_route(f);
      end
    end
    check(hrdata, exp);
  endtask : wrrd
  // Compare every user and pin output against the channel levels, with optional flips
  task automatic cmp_route(input logic [5:0] flip);
    logic [5:0]                ch;
    logic [NUM_ASYNC_USER-1:0] ea;
    logic [NUM_SYNC_USER-1:0]  es;
    ch = exp_chan() ^ flip;
    for (int u = 0; u < NUM_ASYNC_USER; u++) ea[u] = pick(au[u], USEL_LAST, ch);
    for (int u = 0; u < NUM_SYNC_USER; u++) es[u] = pick(su[u], SUSEL_LAST, ch);
    check(32'(a_ev), 32'(ea));
    check(32'(s_ev), 32'(es));
    check(32'(pin), 32'(ea[PIN_USER_BASE +: NUM_PINS] & pen));
    check(32'(pin_oe), 32'(pen));
  endtask : cmp_route
  // Deterministic pass puts every channel on source code 3 and walks async user codes 0-7; sync users get 1 and 3
  task automatic configure(input logic det);
    for (int c = 0; c < NUM_CH; c++) begin
      src[c] = det ? 8'h03 : 8'($urandom_range(0, 34));
      wrrd(src_idx(c), {24'h0, src[c]}, {24'h0, src[c]}, 1'b1);
    end
    for (int u = 0; u < NUM_ASYNC_USER; u++) begin
      au[u] = det ? 8'(u % 8) : 8'($urandom_range(0, 7));
      wrrd(IDX_ASYNC_USER_BASE + 6'(u), {24'h0, au[u]}, {24'h0, au[u]}, 1'b1);
    end
    for (int u = 0; u < NUM_SYNC_USER; u++) begin
      su[u] = det ? 8'(u * 2 + 1) : 8'($urandom_range(0, 3));
      wrrd(IDX_SYNC_USER_BASE + 6'(u), {24'h0, su[u]}, {24'h0, su[u]}, 1'b1);
    end
    pen = 3'($urandom);
    wrrd(IDX_PIN_ENABLE, ($urandom << 3) | 32'(pen), 32'(pen), 1'b1);
  endtask : configure
  // Routing with free-running generators; checked mid-cycle, between edges
  task automatic run_route();
    hold <= 1'b0;
    repeat (30) begin
      @(negedge clk);
      cmp_route(6'h0);
    end
  endtask : run_route
  // Strobe written twice: each write inverts its channels for one cycle only
  task automatic strobe(input logic sync, input logic [7:0] d);
    repeat (2) begin
      wrrd(sync ? IDX_SYNC_STROBE : IDX_ASYNC_STROBE, {24'h0, d}, {24'h0, d}, 1'b1);
    end
  endtask : strobe

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    logic [7:0] pat [5];
    rst_b  = 1'b0;
    hold   = 1'b1;
    hsel   = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr  = 32'h0;
    hwdata = 32'h0;
    pen    = 3'h0;
    checks = 0;
    num_errors = 0;
    foreach (src[c]) src[c] = 8'h00;
    foreach (au[u]) au[u] = 8'h00;
    foreach (su[u]) su[u] = 8'h00;
    void'($urandom(32'h736a));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    run_route();
    // Every register index reads zero straight out of reset
    for (int i = 0; i < 38; i++) begin
      wrrd(6'(i), 32'h0, 32'h0, 1'b0);
      check(hrdata, 32'h0);
    end
    wrrd(6'h06, 32'hFF, 32'h0, 1'b1);
    configure(1'b1);
    run_route();
    pat = '{8'hFF, 8'h00, 8'hA5, 8'h5A, 8'($urandom)};
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (pat[i]) begin
      strobe(1'b0, pat[i]);
      strobe(1'b1, pat[i]);
    end
    repeat (3) begin
      configure(1'b0);
      run_route();
    end
    // Mid-run reset must drop every route and pin enable again
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    foreach (src[c]) src[c] = 8'h00;
    foreach (au[u]) au[u] = 8'h00;
    foreach (su[u]) su[u] = 8'h00;
    pen = 3'h0;
    run_route();
    end_of_test();
  end
endmodule : tb_evrt_top
`default_nettype wire
